//--- logic/mgp_defines.vh
`ifndef MGP_DEFINES_VH
`define MGP_DEFINES_VH

// ----------------------------------------------------------------
// Port map: index of each port, eight bit positions per port
// ----------------------------------------------------------------
`define MGP_NPORTS        7
`define MGP_PW            8
`define MGP_ALLW          56
`define MGP_P_ADDR        3'h0
`define MGP_P_DATAH       3'h1
`define MGP_P_DATAL       3'h2
`define MGP_P_BUSCTL      3'h3
`define MGP_P_BSTROBE     3'h4
`define MGP_P_CSEL        3'h5
`define MGP_P_AUX         3'h6

// ----------------------------------------------------------------
// Per-port masks, port 0 in the low byte
// ----------------------------------------------------------------
// Positions that own a pin
`define MGP_VALID_MASK    56'hff_fe_f0_ff_ff_ff_e0
// Positions with an alternate function (address/chip select, strobes)
`define MGP_ALT_MASK      56'h00_00_f0_00_00_00_e0
// Positions whose function the operating mode fixes (data lanes)
`define MGP_MODE_FIX_MASK 56'h00_00_00_00_ff_ff_00
// Positions that are input-only in their primary function
`define MGP_PRIM_IN_MASK  56'h00_00_00_40_00_00_00

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MGP_BUSCTL_OE_BIT 7
`define MGP_BUSCTL_TA_BIT 6
`define MGP_ASG_RST       56'h00_fe_f0_ff_ff_ff_e0
`define MGP_DOUT_RST      56'h00_00_00_00_00_00_00
`define MGP_DIR_RST       56'h00_00_00_00_00_00_00
`define MGP_ALT_RST       56'h00_00_00_00_00_00_00
`define MGP_IRQ_ASG_RST   7'h7f

// ----------------------------------------------------------------
// Command and readback codes
// ----------------------------------------------------------------
`define MGP_OP_WR_DOUT    3'h0
`define MGP_OP_WR_DIR     3'h1
`define MGP_OP_WR_ASG     3'h2
`define MGP_OP_WR_ALT     3'h3
`define MGP_OP_SET        3'h4
`define MGP_OP_CLR        3'h5
`define MGP_OP_WR_IRQ     3'h6
`define MGP_RD_DOUT       3'h0
`define MGP_RD_DIR        3'h1
`define MGP_RD_PIN        3'h2
`define MGP_RD_ASG        3'h3
`define MGP_RD_ALT        3'h4
`define MGP_RD_IRQ        3'h5

`endif

//--- logic/mgp_sync.v
`timescale 1ns/1ps
`default_nettype none

module mgp_sync
#(
  parameter W = 8
)
(
  input  wire         ref_clk,
  input  wire         reset_n,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  // ------------------------------------------------------------
  // Two-stage synchroniser; first stage feeds only the second
  // ------------------------------------------------------------
  reg [W-1:0] meta_r;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- logic/mgp_pin_mux.v
`timescale 1ns/1ps
`default_nettype none

module mgp_pin_mux
#(
  parameter [7:0] VALID   = 8'hff,
  parameter [7:0] PRIM_IN = 8'h00
)
(
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [7:0] asg,
  input  wire [7:0] alt,
  input  wire [7:0] dout,
  input  wire [7:0] dir,
  input  wire [7:0] prim_out,
  input  wire [7:0] prim_oe,
  input  wire [7:0] alt_out,
  input  wire [7:0] alt_oe,
  output reg  [7:0] pin_out,
  output reg  [7:0] pin_oe
);

  // ------------------------------------------------------------
  // Per-pin function select, registered onto the pad
  // ------------------------------------------------------------
  reg [7:0] out_nxt;
  reg [7:0] oe_nxt;
  reg [7:0] fn_out;
  reg [7:0] fn_oe;

  always @*
  begin
    // Primary or alternate function when assigned away from GPIO
    fn_out  = (alt & alt_out) | (~alt & prim_out);
    fn_oe   = ((alt & alt_oe) | (~alt & prim_oe)) & ~(PRIM_IN & ~alt);
    // GPIO output drives stored data whenever direction is output
    out_nxt = ((asg & fn_out) | (~asg & dout)) & VALID;
    oe_nxt  = ((asg & fn_oe) | (~asg & dir)) & VALID;
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end
    else
    begin
      pin_out <= out_nxt;
      pin_oe  <= oe_nxt;
    end
  end

endmodule

`default_nettype wire

//--- logic/mgp_top.v
// Notes on behaviour
// - Pins are grouped into ports of up to eight bit positions each.
// - Some ports use fewer than eight positions; unused ones have no pin.
// - Address, data, bus-control, strobe and chip-select ports reset to bus use.
// - All other ports reset to general-purpose I/O.
// - Software may switch bus ports to GPIO via pin-assignment writes.
// - Operating mode can fix a pin's function, overriding software.
// - Primary-function select exists for interrupt pins 7 to 1, no GPIO.
// - Each port has output data, per-bit direction and pin-level readback.
// - Separate set and clear accesses modify output data bits directly.
// - Address 23..21 are upper-address bits 7..5; chip selects 6..4 alternate.
// - Byte strobes 3..0 are strobe port bits 7..4; CAS 3..0 alternate.
// - Data 15..8 and 7..0 map to bits 7..0 of the two data ports.
`timescale 1ns/1ps
`default_nettype none
`include "mgp_defines.vh"

module mgp_top
(
  input  wire        ref_clk,
  input  wire        reset_n,
  // Software command port
  input  wire        cmd_valid,
  input  wire [2:0]  cmd_port,
  input  wire [2:0]  cmd_op,
  input  wire [7:0]  cmd_wdata,
  input  wire [2:0]  rd_port,
  input  wire [2:0]  rd_kind,
  output reg  [7:0]  rd_data,
  // Operating-mode strap from a pin
  input  wire        mode_fix_pin,
  // Peripheral side of the muxed pins, port p at bits 8p+7..8p
  input  wire [55:0] prim_out,
  input  wire [55:0] prim_oe,
  input  wire [55:0] alt_out,
  input  wire [55:0] alt_oe,
  output wire [55:0] pin_level,
  // Pad side
  input  wire [55:0] pin_in,
  output wire [55:0] pin_out,
  output wire [55:0] pin_oe,
  // Interrupt pin function selects, bit 0 stands for interrupt 1
  output reg  [6:0]  irq_primary_sel
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [7:0] f_byte;
    input [55:0] v;
    input [2:0]  p;
    begin
      case (p)
        3'h0:    f_byte = v[7:0];
        3'h1:    f_byte = v[15:8];
        3'h2:    f_byte = v[23:16];
        3'h3:    f_byte = v[31:24];
        3'h4:    f_byte = v[39:32];
        3'h5:    f_byte = v[47:40];
        3'h6:    f_byte = v[55:48];
        default: f_byte = 8'h00;
      endcase
    end
  endfunction

  // Set and clear act only where the written bit is one
  function [7:0] f_setclr;
    input [7:0] old;
    input [7:0] wd;
    input       is_set;
    begin
      if (is_set)
        f_setclr = old | wd;
      else
        f_setclr = old & ~wd;
    end
  endfunction

  // ------------------------------------------------------------
  // Registers and synchronised pins
  // ------------------------------------------------------------
  localparam [55:0] valid_m   = `MGP_VALID_MASK;
  localparam [55:0] alt_m     = `MGP_ALT_MASK;
  localparam [55:0] prim_in_m = `MGP_PRIM_IN_MASK;
  reg  [55:0] dout_r;
  reg  [55:0] dir_r;
  reg  [55:0] asg_r;
  reg  [55:0] alt_r;
  reg  [55:0] dout_nxt;
  reg  [55:0] dir_nxt;
  reg  [55:0] asg_nxt;
  reg  [55:0] alt_nxt;
  reg  [6:0]  irq_nxt;
  reg  [7:0]  rd_nxt;
  wire [56:0] sync_q;
  wire        mode_fix;
  wire [55:0] asg_eff;
  reg  [7:0]  cur;
  integer     i;

  mgp_sync #(.W(57)) u_sync
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({mode_fix_pin, pin_in}),
    .sync_out (sync_q)
  );

  assign pin_level = sync_q[55:0];
  assign mode_fix  = sync_q[56];

  // Mode-fixed positions stay on their bus function whatever is written
  assign asg_eff = asg_r | ({56{mode_fix}} & `MGP_MODE_FIX_MASK);

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  always @*
  begin
    dout_nxt = dout_r;
    dir_nxt  = dir_r;
    asg_nxt  = asg_r;
    alt_nxt  = alt_r;
    irq_nxt  = irq_primary_sel;
    cur      = 8'h00;
    // One pass per port keeps every position under the same decode
    for (i = 0; i < `MGP_NPORTS; i = i + 1)
    begin
      if (cmd_valid && (cmd_port == i[2:0]))
      begin
        case (cmd_op)
          `MGP_OP_WR_DOUT:
            dout_nxt[i*8 +: 8] = cmd_wdata
                                 & valid_m[i*8 +: 8];
          `MGP_OP_WR_DIR:
            dir_nxt[i*8 +: 8] = cmd_wdata
                                & valid_m[i*8 +: 8];
          `MGP_OP_WR_ASG:
            asg_nxt[i*8 +: 8] = cmd_wdata
                                & valid_m[i*8 +: 8];
          `MGP_OP_WR_ALT:
            alt_nxt[i*8 +: 8] = cmd_wdata
                                & alt_m[i*8 +: 8];
          `MGP_OP_SET:
          begin
            cur = dout_r[i*8 +: 8];
            dout_nxt[i*8 +: 8] = f_setclr(cur, cmd_wdata, 1'b1)
                                 & valid_m[i*8 +: 8];
          end
          `MGP_OP_CLR:
          begin
            cur = dout_r[i*8 +: 8];
            dout_nxt[i*8 +: 8] = f_setclr(cur, cmd_wdata, 1'b0);
          end
          default:
            cur = 8'h00;
        endcase
      end
    end
    // Interrupt selects are not tied to any port index
    if (cmd_valid && (cmd_op == `MGP_OP_WR_IRQ))
      irq_nxt = cmd_wdata[6:0];
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dout_r          <= `MGP_DOUT_RST;
      dir_r           <= `MGP_DIR_RST;
      asg_r           <= `MGP_ASG_RST;
      alt_r           <= `MGP_ALT_RST;
      irq_primary_sel <= `MGP_IRQ_ASG_RST;
    end
    else
    begin
      dout_r          <= dout_nxt;
      dir_r           <= dir_nxt;
      asg_r           <= asg_nxt;
      alt_r           <= alt_nxt;
      irq_primary_sel <= irq_nxt;
    end
  end

  // ------------------------------------------------------------
  // Readback
  // ------------------------------------------------------------
  always @*
  begin
    case (rd_kind)
      `MGP_RD_DOUT: rd_nxt = f_byte(dout_r, rd_port);
      `MGP_RD_DIR:  rd_nxt = f_byte(dir_r, rd_port);
      `MGP_RD_PIN:  rd_nxt = f_byte(pin_level & `MGP_VALID_MASK,
                                    rd_port);
      `MGP_RD_ASG:  rd_nxt = f_byte(asg_eff, rd_port);
      `MGP_RD_ALT:  rd_nxt = f_byte(alt_r, rd_port);
      `MGP_RD_IRQ:  rd_nxt = {1'b0, irq_primary_sel};
      default:      rd_nxt = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data <= 8'h00;
    else
      rd_data <= rd_nxt;
  end

  // ------------------------------------------------------------
  // Pin muxes, one per port
  // ------------------------------------------------------------
  // Address (bits 7..5, chip-select alternate)
  mgp_pin_mux #(.VALID(8'he0), .PRIM_IN(8'h00)) u_mux_addr
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .asg      (asg_eff[7:0]),
    .alt      (alt_r[7:0]),
    .dout     (dout_r[7:0]),
    .dir      (dir_r[7:0]),
    .prim_out (prim_out[7:0]),
    .prim_oe  (prim_oe[7:0]),
    .alt_out  (alt_out[7:0]),
    .alt_oe   (alt_oe[7:0]),
    .pin_out  (pin_out[7:0]),
    .pin_oe   (pin_oe[7:0])
  );

  // Upper data byte, data 15..8 on bits 7..0
  mgp_pin_mux #(.VALID(8'hff), .PRIM_IN(8'h00)) u_mux_datah
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .asg      (asg_eff[15:8]),
    .alt      (alt_r[15:8]),
    .dout     (dout_r[15:8]),
    .dir      (dir_r[15:8]),
    .prim_out (prim_out[15:8]),
    .prim_oe  (prim_oe[15:8]),
    .alt_out  (alt_out[15:8]),
    .alt_oe   (alt_oe[15:8]),
    .pin_out  (pin_out[15:8]),
    .pin_oe   (pin_oe[15:8])
  );

  // Lower data byte, data 7..0 on bits 7..0
  mgp_pin_mux #(.VALID(8'hff), .PRIM_IN(8'h00)) u_mux_datal
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .asg      (asg_eff[23:16]),
    .alt      (alt_r[23:16]),
    .dout     (dout_r[23:16]),
    .dir      (dir_r[23:16]),
    .prim_out (prim_out[23:16]),
    .prim_oe  (prim_oe[23:16]),
    .alt_out  (alt_out[23:16]),
    .alt_oe   (alt_oe[23:16]),
    .pin_out  (pin_out[23:16]),
    .pin_oe   (pin_oe[23:16])
  );

  // Bus control; acknowledge on bit 6 is never driven in bus use
  mgp_pin_mux #(.VALID(8'hff), .PRIM_IN(prim_in_m[31:24])) u_mux_busctl
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .asg      (asg_eff[31:24]),
    .alt      (alt_r[31:24]),
    .dout     (dout_r[31:24]),
    .dir      (dir_r[31:24]),
    .prim_out (prim_out[31:24]),
    .prim_oe  (prim_oe[31:24]),
    .alt_out  (alt_out[31:24]),
    .alt_oe   (alt_oe[31:24]),
    .pin_out  (pin_out[31:24]),
    .pin_oe   (pin_oe[31:24])
  );

  // Byte strobes 3..0 on bits 7..4, CAS alternate
  mgp_pin_mux #(.VALID(8'hf0), .PRIM_IN(8'h00)) u_mux_bstrobe
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .asg      (asg_eff[39:32]),
    .alt      (alt_r[39:32]),
    .dout     (dout_r[39:32]),
    .dir      (dir_r[39:32]),
    .prim_out (prim_out[39:32]),
    .prim_oe  (prim_oe[39:32]),
    .alt_out  (alt_out[39:32]),
    .alt_oe   (alt_oe[39:32]),
    .pin_out  (pin_out[39:32]),
    .pin_oe   (pin_oe[39:32])
  );

  // Chip selects 7..1; select 0 has no GPIO position
  mgp_pin_mux #(.VALID(8'hfe), .PRIM_IN(8'h00)) u_mux_csel
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .asg      (asg_eff[47:40]),
    .alt      (alt_r[47:40]),
    .dout     (dout_r[47:40]),
    .dir      (dir_r[47:40]),
    .prim_out (prim_out[47:40]),
    .prim_oe  (prim_oe[47:40]),
    .alt_out  (alt_out[47:40]),
    .alt_oe   (alt_oe[47:40]),
    .pin_out  (pin_out[47:40]),
    .pin_oe   (pin_oe[47:40])
  );

  // General port outside the bus group, GPIO from reset
  mgp_pin_mux #(.VALID(8'hff), .PRIM_IN(8'h00)) u_mux_aux
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .asg      (asg_eff[55:48]),
    .alt      (alt_r[55:48]),
    .dout     (dout_r[55:48]),
    .dir      (dir_r[55:48]),
    .prim_out (prim_out[55:48]),
    .prim_oe  (prim_oe[55:48]),
    .alt_out  (alt_out[55:48]),
    .alt_oe   (alt_oe[55:48]),
    .pin_out  (pin_out[55:48]),
    .pin_oe   (pin_oe[55:48])
  );

endmodule

`default_nettype wire

//--- verification/mgp_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

module mgp_pad_model
(
  input  wire logic [55:0] pin_out,
  input  wire logic [55:0] pin_oe,
  input  wire logic [55:0] ext_level,
  output wire logic [55:0] pin_in
);
  // A driven pad reads back its own level; an input pad sees the board
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

`default_nettype wire

//--- verification/mgp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgp_defines.vh"

module mgp_top_sva
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_port,
  input wire logic [2:0]  cmd_op,
  input wire logic [7:0]  cmd_wdata,
  input wire logic [7:0]  rd_data,
  input wire logic        mode_fix_pin,
  input wire logic [55:0] prim_out,
  input wire logic [55:0] prim_oe,
  input wire logic [55:0] pin_in,
  input wire logic [55:0] pin_level,
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe,
  input wire logic [6:0]  irq_primary_sel
);
  // ------------
  // Helpers
  // ------------
  logic [1:0] rcnt_r;
  logic [2:0] mcnt_r;
  wire        aux = cmd_valid && cmd_port == `MGP_P_AUX;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rcnt_r <= 2'h0;
      mcnt_r <= 3'h0;
    end
    else
    begin
      rcnt_r <= (rcnt_r == 2'h3) ? rcnt_r : rcnt_r + 2'h1;
      // Strap must be seen long enough to pass the sync flops
      mcnt_r <= !mode_fix_pin ? 3'h0 :
                (mcnt_r == 3'h7) ? mcnt_r : mcnt_r + 3'h1;
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_reset_values:
    assert property ($rose(reset_n) |-> pin_oe == 56'h0 && rd_data == 8'h0
      && irq_primary_sel == 7'h7f) else $error("reset values wrong");
  a_dout_write:
    assert property (!cmd_valid ##1 (aux && cmd_op == `MGP_OP_WR_DOUT)
      ##1 !cmd_valid |=> pin_out[55:48] == $past(cmd_wdata, 2))
      else $error("aux data not driven");
  a_dir_oe:
    assert property (!cmd_valid ##1 (aux && cmd_op == `MGP_OP_WR_DIR)
      ##1 !cmd_valid |=> pin_oe[55:48] == $past(cmd_wdata, 2))
      else $error("aux direction not applied");
  a_set_bits:
    assert property (!cmd_valid ##1 (aux && cmd_op == `MGP_OP_SET)
      ##1 !cmd_valid |=> pin_out[55:48] ==
      ($past(pin_out[55:48], 2) | $past(cmd_wdata, 2)))
      else $error("set access wrong");
  a_clear_bits:
    assert property (!cmd_valid ##1 (aux && cmd_op == `MGP_OP_CLR)
      ##1 !cmd_valid |=> pin_out[55:48] ==
      ($past(pin_out[55:48], 2) & ~$past(cmd_wdata, 2)))
      else $error("clear access wrong");
  a_irq_select:
    assert property ((cmd_valid && cmd_op == `MGP_OP_WR_IRQ) ##1
      !(cmd_valid && cmd_op == `MGP_OP_WR_IRQ) |=>
      irq_primary_sel == $past(cmd_wdata[6:0], 2))
      else $error("irq select not stored");
  a_unused_quiet:
    assert property ((pin_oe & ~`MGP_VALID_MASK) == 56'h0)
      else $error("unused position driven");
  a_level_sync:
    assert property (rcnt_r == 2'h3 |-> pin_level == $past(pin_in, 2))
      else $error("pin level not two cycles behind");
  a_mode_fixed:
    assert property (mcnt_r >= 3'h5 |->
      pin_out[23:8] == $past(prim_out[23:8]) &&
      pin_oe[23:8] == $past(prim_oe[23:8]))
      else $error("data lanes not on bus use");
endmodule

bind mgp_top mgp_top_sva chk_u (.*);

`default_nettype wire

//--- verification/muxed_gpio_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgp_defines.vh"

module muxed_gpio_ports_test;
  localparam logic [55:0] vm_c = `MGP_VALID_MASK;
  logic        ref_clk;
  logic        reset_n;
  logic        cmd_valid;
  logic [2:0]  cmd_port;
  logic [2:0]  cmd_op;
  logic [7:0]  cmd_wdata;
  logic [2:0]  rd_port;
  logic [2:0]  rd_kind;
  logic        mode_fix_pin;
  logic [55:0] prim_out;
  logic [55:0] prim_oe;
  logic [55:0] alt_out;
  logic [55:0] alt_oe;
  logic [55:0] ext_level;
  wire  [7:0]  rd_data;
  wire  [55:0] pin_level;
  wire  [55:0] pin_in;
  wire  [55:0] pin_out;
  wire  [55:0] pin_oe;
  wire  [6:0]  irq_primary_sel;
  int          mismatches;
  int          samples_checked;
  logic [7:0]  d;

  mgp_top       dut_u (.*);
  mgp_pad_model pad_u (.*);

  // ------------
  // Tasks
  // ------------
  task automatic chk(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(input logic [2:0] p, o, input logic [7:0] w);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_port = p;
    cmd_op = o;
    cmd_wdata = w;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic rchk(input string w, input logic [2:0] p, k,
                      input logic [7:0] exp);
    rd_port = p;
    rd_kind = k;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(w, rd_data, exp);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_reset;
    for (int p = 0; p < 7; p++)
    begin
      d = (p < 6) ? vm_c[8*p +: 8] : 8'h00;
      rchk("assign", 3'(p), `MGP_RD_ASG, d);
    end
    rchk("irq sel", 3'h0, `MGP_RD_IRQ, 8'h7f);
  endtask

  task automatic t_gpio;
    cmd(`MGP_P_AUX, `MGP_OP_WR_DIR, 8'hff);
    cmd(`MGP_P_AUX, `MGP_OP_WR_DOUT, 8'ha5);
    settle;
    chk("aux oe", pin_oe[55:48], 8'hff);
    chk("aux out", pin_out[55:48], 8'ha5);
    cmd(`MGP_P_AUX, `MGP_OP_SET, 8'h0a);
    settle;
    chk("aux set", pin_out[55:48], 8'haf);
    cmd(`MGP_P_AUX, `MGP_OP_CLR, 8'h81);
    settle;
    chk("aux clr", pin_out[55:48], 8'h2e);
    rchk("aux data", `MGP_P_AUX, `MGP_RD_DOUT, 8'h2e);
    ext_level[55:48] = 8'h3c;
    cmd(`MGP_P_AUX, `MGP_OP_WR_DIR, 8'h0f);
    settle;
    rchk("aux pin", `MGP_P_AUX, `MGP_RD_PIN, 8'h3e);
  endtask

  task automatic t_bus;
    cmd(`MGP_P_ADDR, `MGP_OP_WR_ASG, 8'h00);
    cmd(`MGP_P_ADDR, `MGP_OP_WR_DIR, 8'hff);
    settle;
    chk("addr oe", pin_oe[7:0], 8'he0);
    chk("addr gpio", pin_out[7:0], 8'h00);
    rchk("addr dir", `MGP_P_ADDR, `MGP_RD_DIR, 8'he0);
    cmd(`MGP_P_ADDR, `MGP_OP_WR_ASG, 8'hff);
    cmd(`MGP_P_ADDR, `MGP_OP_WR_ALT, 8'hff);
    cmd(`MGP_P_BSTROBE, `MGP_OP_WR_ALT, 8'hff);
    settle;
    chk("addr alt", pin_out[7:0], alt_out[7:0] & 8'he0);
    chk("bs alt", pin_out[39:32], alt_out[39:32] & 8'hf0);
    rchk("bs alt", `MGP_P_BSTROBE, `MGP_RD_ALT, 8'hf0);
    cmd(`MGP_P_ADDR, `MGP_OP_WR_ALT, 8'h00);
    settle;
    chk("addr prim", pin_out[7:0], prim_out[7:0] & 8'he0);
    chk("busctl oe", pin_oe[31:24], 8'hbf);
  endtask

  task automatic t_mode;
    mode_fix_pin = 1'b1;
    cmd(`MGP_P_DATAL, `MGP_OP_WR_ASG, 8'h00);
    cmd(`MGP_P_DATAL, `MGP_OP_WR_DIR, 8'hff);
    settle;
    chk("datal fix", pin_out[23:16], prim_out[23:16]);
    rchk("datal asg", `MGP_P_DATAL, `MGP_RD_ASG, 8'hff);
    mode_fix_pin = 1'b0;
    settle;
    settle;
    chk("datal gpio", pin_oe[23:16], 8'hff);
    chk("datal out", pin_out[23:16], 8'h00);
    chk("datah prim", pin_out[15:8], prim_out[15:8]);
  endtask

  task automatic t_irq;
    cmd(3'h0, `MGP_OP_WR_IRQ, 8'h2a);
    settle;
    chk("irq sel", {1'b0, irq_primary_sel}, 8'h2a);
    rchk("irq read", 3'h0, `MGP_RD_IRQ, 8'h2a);
  endtask

  // ------------
  // Run
  // ------------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial
  begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_port = 3'h0;
    cmd_op = 3'h0;
    cmd_wdata = 8'h00;
    rd_port = 3'h0;
    rd_kind = 3'h0;
    mode_fix_pin = 1'b0;
    prim_out = 56'h96_5a_c3_3c_a5_69_f0;
    prim_oe = {56{1'b1}};
    alt_out = ~prim_out;
    alt_oe = {56{1'b1}};
    ext_level = 56'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_reset;
    t_gpio;
    t_bus;
    t_mode;
    t_irq;
    report_and_stop;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    report_and_stop;
  end
endmodule

`default_nettype wire
